//--- shared/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_OSC_STATUS  = 8'h1d;
  localparam logic [7:0] ADDR_CONFIG_KEY  = 8'h1f;

  // ==========================================================================
  // Reset values and key codes.
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET     = 8'h22;
  localparam logic [7:0] KEY_CLEARED      = 8'h00;
  localparam logic [7:0] KEY_OSC_UNLOCK   = 8'ha1;

  // ==========================================================================
  // Control field positions.
  localparam int CTL_SOURCE_SELECT = 7;
  localparam int CTL_CAL_MODE_HI   = 6;
  localparam int CTL_CAL_MODE_LO   = 5;
  localparam int CTL_BATTERY_SW    = 4;
  localparam int CTL_FAILURE_SW    = 3;
  localparam int CTL_FAIL_IRQ_EN   = 1;
  localparam int CTL_CALFAIL_IRQ_EN = 0;

  // Status field positions.
  localparam int STS_TRIM_HI       = 7;
  localparam int STS_TRIM_LO       = 6;
  localparam int STS_SECOND_OUTPUT_PIN_LOCK     = 5;
  localparam int STS_ACTIVE_SOURCE = 4;
  localparam int STS_OSC_FAIL      = 1;
  localparam int STS_CALFAIL       = 0;

  // Writable bits of the status register (active source is read only).
  localparam logic [7:0] STATUS_WR_MASK = 8'he3;

  // ==========================================================================
  // Timing: crystal trim step and the low-frequency failure threshold.
  localparam int TRIM_STEP_PPM     = 122;
  localparam int FAIL_FREQ_HZ      = 8000;

  // ==========================================================================
  // Register port transaction carried as one struct.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Oscillator source encoding.
  typedef enum logic {
    SRC_CRYSTAL = 1'b0,
    SRC_RC      = 1'b1
  } osc_source_t;

  // Calibration sequencer states.
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;

  // A calibration mode of zero means no calibration.
  function automatic logic cal_requested(input logic [7:0] ctl);
    cal_requested = (ctl[CTL_CAL_MODE_HI:CTL_CAL_MODE_LO] != 2'b00);
  endfunction : cal_requested

endpackage : osc_ctrl_pkg

//--- hw/osc_source_mux.sv
`timescale 1ns/1ns
// ==========================================================================
// Source arbiter: picks the oscillator that actually drives the clocks.
module osc_source_mux (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      source_select,
  input  wire logic                      battery_switch_enable,
  input  wire logic                      failure_switch_enable,
  input  wire logic                      on_battery,
  input  wire logic                      osc_fail_event,
  input  wire logic                      crystal_running,
  output osc_ctrl_pkg::osc_source_t      active_source
);
  import osc_ctrl_pkg::*;

  osc_source_t active_r;
  osc_source_t active_nxt;

  // Forced RC has priority; a move to crystal needs a running crystal.
  always_comb begin
    active_nxt = active_r;
    if (battery_switch_enable && on_battery) begin
      active_nxt = SRC_RC;
    end else if (failure_switch_enable && osc_fail_event) begin
      active_nxt = SRC_RC;
    end else if (source_select) begin
      active_nxt = SRC_RC;
    end else if (crystal_running) begin
      active_nxt = SRC_CRYSTAL;
    end
  end

  // Holds the source in use.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_r <= SRC_CRYSTAL;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign active_source = active_r;

endmodule : osc_source_mux

//--- hw/osc_cal_seq.sv
`timescale 1ns/1ns
// ==========================================================================
// Autocalibration launcher: issues a start and waits for the engine result.
module osc_cal_seq (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic cal_done,
  input  wire logic cal_ok,
  output logic      cal_start,
  output logic      cal_busy,
  output logic      cal_fail_event
);
  import osc_ctrl_pkg::*;

  cal_state_t state_r;

  // Start pulse goes out in the cycle after the accepted write.
  // A start that lands in the wind-down cycle still launches a new run,
  // so no accepted write is ever lost. Busy is a flop of its own so the
  // output never carries decode glitches.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r        <= CAL_IDLE;
      cal_start      <= 1'b0;
      cal_busy       <= 1'b0;
      cal_fail_event <= 1'b0;
    end else begin
      cal_start      <= 1'b0;
      cal_fail_event <= 1'b0;
      unique case (state_r)
        CAL_IDLE, CAL_DONE: begin
          if (start) begin
            state_r   <= CAL_RUN;
            cal_busy  <= 1'b1;
            cal_start <= 1'b1;
          end else begin
            state_r  <= CAL_IDLE;
            cal_busy <= 1'b0;
          end
        end
        CAL_RUN: begin
          if (start) begin
            cal_start <= 1'b1;
          end else if (cal_done) begin
            state_r        <= CAL_DONE;
            cal_busy       <= 1'b0;
            cal_fail_event <= !cal_ok;
          end
        end
        default: begin
          state_r  <= CAL_IDLE;
          cal_busy <= 1'b0;
        end
      endcase
    end
  end

endmodule : osc_cal_seq

//--- hw/oscillator_select_control.sv
`timescale 1ns/1ns
module oscillator_select_control (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  osc_ctrl_pkg::reg_req_t    req,
  input  wire logic                 on_battery,
  input  wire logic                 crystal_running,
  input  wire logic                 crystal_slow,
  input  wire logic                 cal_done,
  input  wire logic                 cal_ok,
  input  wire logic                 second_output_pin_write,
  input  wire logic                 second_output_pin_wdata,
  output logic [7:0]                rdata,
  output logic                      irq,
  output logic                      active_source,
  output logic [1:0]                crystal_trim,
  output logic                      second_output_level,
  output logic                      cal_start,
  output logic                      cal_busy
);
  import osc_ctrl_pkg::*;

  // ========================================================================
  // Registers.
  logic [7:0]  control_r;
  logic [7:0]  status_r;
  logic [7:0]  key_r;
  logic        irq_r;
  logic        second_r;
  logic [7:0]  rdata_r;
  osc_source_t active_src;
  logic        cal_fail_event;
  logic        fail_event;
  logic        ctl_write_ok;
  logic        sts_write;

  // A crystal running below the failure threshold is a failure event.
  assign fail_event   = crystal_slow;

  // Control writes only land while the unlock key is present.
  assign ctl_write_ok = req.wr && (req.addr == ADDR_OSC_CONTROL)
                        && (key_r == KEY_OSC_UNLOCK);
  assign sts_write    = req.wr && (req.addr == ADDR_OSC_STATUS);

  // ========================================================================
  // Key register: loaded by its own write, cleared by any other write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_r <= KEY_CLEARED;
    end else if (req.wr) begin
      if (req.addr == ADDR_CONFIG_KEY) begin
        key_r <= req.wdata;
      end else begin
        key_r <= KEY_CLEARED;
      end
    end
  end

  // Control register; reserved bit 2 stays zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_r <= CONTROL_RESET;
    end else if (ctl_write_ok) begin
      control_r <= req.wdata & 8'hfb;
    end
  end

  // ========================================================================
  // Status register: trim, lock and sticky failure flags.
  // A hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= STATUS_RESET;
    end else begin
      if (sts_write) begin
        status_r[STS_TRIM_HI:STS_TRIM_LO] <= req.wdata[STS_TRIM_HI:STS_TRIM_LO];
        status_r[STS_SECOND_OUTPUT_PIN_LOCK]           <= req.wdata[STS_SECOND_OUTPUT_PIN_LOCK];
      end
      if (fail_event) begin
        status_r[STS_OSC_FAIL] <= 1'b1;
      end else if (sts_write && !req.wdata[STS_OSC_FAIL]) begin
        status_r[STS_OSC_FAIL] <= 1'b0;
      end
      if (cal_fail_event) begin
        status_r[STS_CALFAIL] <= 1'b1;
      end else if (sts_write && !req.wdata[STS_CALFAIL]) begin
        status_r[STS_CALFAIL] <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Source arbitration.
  osc_source_mux u_mux (
    .clk                   (clk),
    .nrst                  (nrst),
    .source_select         (control_r[CTL_SOURCE_SELECT]),
    .battery_switch_enable (control_r[CTL_BATTERY_SW]),
    .failure_switch_enable (control_r[CTL_FAILURE_SW]),
    .on_battery            (on_battery),
    .osc_fail_event        (fail_event),
    .crystal_running       (crystal_running),
    .active_source         (active_src)
  );

  // Calibration launcher, triggered by an accepted control write.
  osc_cal_seq u_cal (
    .clk            (clk),
    .nrst           (nrst),
    .start          (ctl_write_ok && cal_requested(req.wdata)),
    .cal_done       (cal_done),
    .cal_ok         (cal_ok),
    .cal_start      (cal_start),
    .cal_busy       (cal_busy),
    .cal_fail_event (cal_fail_event)
  );

  // ========================================================================
  // Interrupt: level while any enabled flag is set.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (control_r[CTL_FAIL_IRQ_EN] && status_r[STS_OSC_FAIL])
            || (control_r[CTL_CALFAIL_IRQ_EN] && status_r[STS_CALFAIL]);
    end
  end

  // Second output level; the lock only stops it from being set.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      second_r <= 1'b0;
    end else if (second_output_pin_write) begin
      if (!(second_output_pin_wdata && status_r[STS_SECOND_OUTPUT_PIN_LOCK])) begin
        second_r <= second_output_pin_wdata;
      end
    end
  end

  // Read data, registered one cycle after the read request.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_OSC_CONTROL: rdata_r <= control_r;
        ADDR_OSC_STATUS: begin
          rdata_r                    <= status_r & STATUS_WR_MASK;
          rdata_r[STS_ACTIVE_SOURCE] <= active_src;
        end
        default:          rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata               = rdata_r;
  assign irq                 = irq_r;
  assign active_source       = active_src;
  assign crystal_trim        = status_r[STS_TRIM_HI:STS_TRIM_LO];
  assign second_output_level = second_r;

endmodule : oscillator_select_control

//--- test/osc_sel_monitor.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker for the oscillator select control.
module osc_sel_monitor
  import osc_ctrl_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input osc_ctrl_pkg::reg_req_t req,
  input wire logic              on_battery,
  input wire logic              crystal_running,
  input wire logic              crystal_slow,
  input wire logic              cal_done,
  input wire logic              cal_ok,
  input wire logic              second_output_pin_write,
  input wire logic              second_output_pin_wdata,
  input wire logic [7:0]        rdata,
  input wire logic              irq,
  input wire logic              active_source,
  input wire logic [1:0]        crystal_trim,
  input wire logic              second_output_level,
  input wire logic              cal_start,
  input wire logic              cal_busy
);
  logic       key_r;
  logic       lock_r;
  logic [7:0] ctl_r;
  logic       wc;

  // An accepted control write needs the unlock code in the previous write.
  assign wc = req.wr && req.addr == ADDR_OSC_CONTROL && key_r;

  // Shadow the key match, the output lock and the control register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_r  <= 1'b0;
      lock_r <= 1'b1;
      ctl_r  <= 8'h00;
    end else if (req.wr) begin
      key_r <= req.addr == ADDR_CONFIG_KEY && req.wdata == KEY_OSC_UNLOCK;
      if (req.addr == ADDR_OSC_STATUS) lock_r <= req.wdata[5];
      if (wc) ctl_r <= req.wdata;
    end
  end

  // ==========================================================
  // Properties.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  cal_launch_a:
  assert property (wc && req.wdata[6:5] != 2'b00 |=> cal_start) else $error("no cal_start");
  ctl_read_a:
  assert property (req.rd && req.addr == ADDR_OSC_CONTROL |=> rdata == ($past(ctl_r) & 8'hfb))
    else $error("control readback wrong");
  src_hold_a:
  assert property (active_source && !crystal_running |=> active_source) else $error("left rc");
  batt_rc_a:
  assert property ((ctl_r[4] && on_battery)[*3] |-> active_source) else $error("no battery rc");
  irq_cause_a:
  assert property (irq |-> $past(ctl_r[1] || ctl_r[0])) else $error("irq without enable");
  fail_irq_a:
  assert property ((crystal_slow && ctl_r[1])[*3] |-> irq) else $error("no fail irq");
  calfail_irq_a:
  assert property (cal_done && !cal_ok && cal_busy && ctl_r[0] |-> ##[1:4] irq)
    else $error("no calfail irq");
  second_output_pin_lock_a:
  assert property (second_output_pin_write && second_output_pin_wdata && lock_r && !second_output_level
    |=> !second_output_level) else $error("locked output set");
  cover property (cal_start);
  cover property (irq);
  cover property (active_source && !crystal_running);
endmodule : osc_sel_monitor

bind oscillator_select_control osc_sel_monitor mon (.*);

//--- test/tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the oscillator select control.
module tb_top;
  import osc_ctrl_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  reg_req_t   req = '0;
  logic       on_battery = 1'b0;
  logic       crystal_running = 1'b1;
  logic       crystal_slow = 1'b0;
  logic       cal_done = 1'b0;
  logic       cal_ok = 1'b0;
  logic       second_output_pin_write = 1'b0;
  logic       second_output_pin_wdata = 1'b0;
  logic [7:0] rdata;
  logic       irq, active_source, second_output_level, cal_start, cal_busy;
  logic [1:0] crystal_trim;
  logic [7:0] expq[$];
  logic       rd_pend = 1'b0;
  logic [7:0] rnd;
  int         failures = 0;
  int         num_checks = 0;
  int         seed = 32'h71d3;

  oscillator_select_control dut (.*);

  // Clock of 50 ns period.
  initial forever #25 clk = ~clk;

  // ==========================================================
  // Compare, verdict and drive tasks.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
  endtask : w

  task automatic r(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
  endtask : r

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic ctl(input logic [7:0] d);
    w(ADDR_CONFIG_KEY, KEY_OSC_UNLOCK);
    w(ADDR_OSC_CONTROL, d);
  endtask : ctl

  task automatic cal(input logic ok);
    idle(1);
    for (int i = 0; i < 8 && cal_busy !== 1'b1; i++) @(posedge clk);
    chk("cal_busy", 8'h01, {7'h00, cal_busy});
    cal_done <= 1'b1;
    cal_ok   <= ok;
    @(posedge clk);
    cal_done <= 1'b0;
    idle(3);
  endtask : cal

  task automatic second_output_pin(input logic v);
    second_output_pin_write <= 1'b1;
    second_output_pin_wdata <= v;
    @(posedge clk);
    second_output_pin_write <= 1'b0;
    @(posedge clk);
  endtask : second_output_pin

  // Each read answer is compared with the oldest noted value.
  always @(posedge clk) rd_pend <= req.rd;
  always @(negedge clk) if (rd_pend) chk("rdata", expq.pop_front(), rdata);

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    r(ADDR_OSC_STATUS, STATUS_RESET);
    r(ADDR_CONFIG_KEY, 8'h00);
    r(8'h40, 8'h00);
    w(ADDR_OSC_CONTROL, 8'h9b);
    w(ADDR_CONFIG_KEY, KEY_OSC_UNLOCK);
    w(ADDR_OSC_STATUS, STATUS_RESET);
    w(ADDR_OSC_CONTROL, 8'h9b);
    r(ADDR_OSC_CONTROL, CONTROL_RESET);
    for (int m = 0; m < 4; m++) begin
      rnd = $random(seed);
      ctl({1'b0, m[1:0], 2'b00, rnd[2:0]});
      if (m != 0) cal(1'b1);
      r(ADDR_OSC_CONTROL, {1'b0, m[1:0], 3'b000, rnd[1:0]});
    end
    ctl(8'h21);
    cal(1'b0);
    chk("irq", 8'h01, {7'h00, irq});
    r(ADDR_OSC_STATUS, 8'h23);
    w(ADDR_OSC_STATUS, 8'h20);
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    ctl(8'h0a);
    crystal_running <= 1'b0;
    crystal_slow <= 1'b1;
    idle(3);
    crystal_slow <= 1'b0;
    idle(2);
    chk("irq", 8'h01, {7'h00, irq});
    chk("source", 8'h01, {7'h00, active_source});
    r(ADDR_OSC_STATUS, 8'h32);
    w(ADDR_OSC_STATUS, 8'h20);
    crystal_running <= 1'b1;
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    ctl(8'h10);
    on_battery <= 1'b1;
    idle(3);
    chk("source", 8'h01, {7'h00, active_source});
    ctl(8'h00);
    idle(3);
    chk("source", 8'h00, {7'h00, active_source});
    on_battery <= 1'b0;
    ctl(8'h80);
    idle(3);
    chk("source", 8'h01, {7'h00, active_source});
    crystal_running <= 1'b0;
    ctl(8'h00);
    idle(3);
    chk("source", 8'h01, {7'h00, active_source});
    crystal_running <= 1'b1;
    idle(3);
    chk("source", 8'h00, {7'h00, active_source});
    for (int t = 0; t < 4; t++) begin
      w(ADDR_OSC_STATUS, {t[1:0], 6'h20});
      idle(1);
      chk("trim", {6'h00, t[1:0]}, {6'h00, crystal_trim});
    end
    second_output_pin(1'b1);
    chk("second_output_pin", 8'h00, {7'h00, second_output_level});
    w(ADDR_OSC_STATUS, 8'h00);
    idle(1);
    second_output_pin(1'b1);
    chk("second_output_pin", 8'h01, {7'h00, second_output_level});
    conclude();
  end

  // Watchdog against a hang.
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : tb_top
